// File: hw/gpf_pin_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Seven pins, each input, output or alternate
// - Control registers reached via upstream configuration
// - Pins 0,8,9 drive port 2,1,3 resets
// - Pin 2 alternate is expander interrupt input
// - Pin 7 alternate is event output
// - Reset leaves every pin a plain input
// - Inputs synchronised, sampled at least 128 ns apart
// - Unused alternate function held inactive
// - One bit per pin, position equals pin
// - Select wins; else direction picks in/out
// - Input mode captures pin into data bit
// - Data reads return live pin level always
// - Output mode drives data bit onto pin
// - Output mode reads observed pin level
// - Alternate mode follows alternate logic, readable
module gpf_pin_ctrl
    import gpf_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = gpf_pkg::SAMPLE_CYC
) (
    // Clock, reset, enable
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    // Configuration access from the upstream port
    input  wire logic                     cfg_wr_i,
    input  wire logic                     cfg_rd_i,
    input  wire gpf_pkg::gpf_sel_e        cfg_sel_i,
    input  wire logic [gpf_pkg::PIN_W-1:0] cfg_wdata_i,
    output logic      [gpf_pkg::PIN_W-1:0] cfg_rdata_o,
    output logic                          cfg_rvalid_o,
    // Board pins
    input  wire logic [gpf_pkg::PIN_W-1:0] pin_i,
    output logic      [gpf_pkg::PIN_W-1:0] pin_o,
    output logic      [gpf_pkg::PIN_W-1:0] pin_oe_o,
    // Alternate function sources
    input  wire logic                     port2_reset_out_n_i,
    input  wire logic                     port1_reset_out_n_i,
    input  wire logic                     port3_reset_out_n_i,
    input  wire logic                     event_out_n_i,
    // Alternate function sink
    output logic                          expander_irq0_in_n_o
);
    import gpf_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    localparam int unsigned CNT_W = $clog2(SAMPLE_CYCLES + 1);

    logic [PIN_W-1:0] pin_function_select_q; // 1 hands pin to alternate
    logic [PIN_W-1:0] pin_direction_config_q; // 1 means output
    logic [PIN_W-1:0] pin_data_value_q;       // Output latch / input capture
    logic [PIN_W-1:0] pin_lvl;                // Synchronised pin level
    logic [CNT_W-1:0] smp_cnt_q;              // Sample interval counter
    logic             smp_tick;               // One sample strobe
    logic [PIN_W-1:0] alt_val;                // Alternate drive values by pin
    logic [PIN_W-1:0] in_mode;                // Pins in plain input mode
    logic [PIN_W-1:0] out_mode;               // Pins in plain output mode
    logic [PIN_W-1:0] pin_oe_d;               // Next driver enables
    logic [PIN_W-1:0] pin_d;                  // Next pin drive values

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Keep only the implemented pin bits
    function automatic logic [PIN_W-1:0] keep(input logic [PIN_W-1:0] v);
        keep = v & PIN_MASK;
    endfunction : keep

    // ---------------------------------------------------------------
    // Sample strobe
    // ---------------------------------------------------------------
    // Spacing of at least the minimum interval keeps input load low
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            smp_cnt_q <= '0;
        end else if (ce_i) begin
            if (smp_tick) begin
                smp_cnt_q <= '0;
            end else begin
                smp_cnt_q <= smp_cnt_q + 1'b1;
            end
        end
    end

    assign smp_tick = (smp_cnt_q == CNT_W'(SAMPLE_CYCLES - 1));

    // ---------------------------------------------------------------
    // Pin synchroniser
    // ---------------------------------------------------------------
    // Pins are asynchronous; three stages and an agreement check
    gpf_sync3 #(
        .W          (PIN_W)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .tick_i     (smp_tick),
        .d_i        (pin_i),
        .q_o        (pin_lvl)
    );

    // ---------------------------------------------------------------
    // Mode decode
    // ---------------------------------------------------------------
    // Select one wins regardless of direction
    assign in_mode  = keep(~pin_function_select_q & ~pin_direction_config_q);
    assign out_mode = keep(~pin_function_select_q &  pin_direction_config_q);

    // ---------------------------------------------------------------
    // Function select register
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_function_select_q <= FUNC_RST;
        end else if (ce_i && cfg_wr_i && cfg_sel_i == GPF_SEL_FUNC) begin
            pin_function_select_q <= keep(cfg_wdata_i);
        end
    end

    // ---------------------------------------------------------------
    // Direction register
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_direction_config_q <= DIR_RST;
        end else if (ce_i && cfg_wr_i && cfg_sel_i == GPF_SEL_DIR) begin
            pin_direction_config_q <= keep(cfg_wdata_i);
        end
    end

    // ---------------------------------------------------------------
    // Data register
    // ---------------------------------------------------------------
    // Input-mode bits take the sampled level; a software write to
    // such a bit is overwritten, since the pin is what it reports
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_data_value_q <= DATA_RST;
        end else if (ce_i) begin
            if (cfg_wr_i && cfg_sel_i == GPF_SEL_DATA) begin
                pin_data_value_q <= (keep(cfg_wdata_i) & ~in_mode) | (pin_lvl & in_mode);
            end else begin
                pin_data_value_q <= (pin_data_value_q & ~in_mode) | (pin_lvl & in_mode);
            end
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    // Data reads show the live pin in every mode, not the latch
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_rdata_o  <= '0;
            cfg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i) begin
                case (cfg_sel_i)
                    GPF_SEL_FUNC: begin
                        cfg_rdata_o <= pin_function_select_q;
                    end
                    GPF_SEL_DIR: begin
                        cfg_rdata_o <= pin_direction_config_q;
                    end
                    GPF_SEL_DATA: begin
                        cfg_rdata_o <= keep(pin_lvl);
                    end
                    default: begin
                        cfg_rdata_o <= '0; // Unused select reads zero
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Alternate output values
    // ---------------------------------------------------------------
    // Pins without a driving alternate carry zero, never enabled
    always_comb begin
        alt_val            = '0;
        alt_val[PIN_RST2]  = port2_reset_out_n_i;
        alt_val[PIN_RST1]  = port1_reset_out_n_i;
        alt_val[PIN_RST3]  = port3_reset_out_n_i;
        alt_val[PIN_EVENT] = event_out_n_i;
    end

    // ---------------------------------------------------------------
    // Pin drivers
    // ---------------------------------------------------------------
    // Driver on only for plain output or a driving alternate
    assign pin_oe_d = out_mode | keep(pin_function_select_q & ALT_OUT_MASK);
    assign pin_d    = keep((pin_function_select_q & alt_val) |
                           (~pin_function_select_q & pin_data_value_q));

    // Registered so the board sees glitch-free levels
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_o    <= '0;
            pin_oe_o <= '0;
        end else if (ce_i) begin
            pin_o    <= pin_d;
            pin_oe_o <= pin_oe_d;
        end
    end

    // ---------------------------------------------------------------
    // Alternate input
    // ---------------------------------------------------------------
    // Held idle while the pin serves as plain I/O so a stray level
    // cannot raise an expander interrupt
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            expander_irq0_in_n_o <= IRQ_IDLE;
        end else if (ce_i) begin
            if (pin_function_select_q[PIN_IRQ0]) begin
                expander_irq0_in_n_o <= pin_lvl[PIN_IRQ0];
            end else begin
                expander_irq0_in_n_o <= IRQ_IDLE;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_reset_defaults: assert property (@(posedge core_clk_i)
        $fell(rst_i) |-> (pin_function_select_q == FUNC_RST) && (pin_direction_config_q == DIR_RST)
                         && (pin_oe_o == '0))
        else $error("pins not all inputs after reset");

    a_unimpl_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (pin_oe_o & ~PIN_MASK) == '0 && (pin_function_select_q & ~PIN_MASK) == '0)
        else $error("unimplemented pin active");

    a_write_lands: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && cfg_wr_i && cfg_sel_i == GPF_SEL_DIR |=> pin_direction_config_q == $past(cfg_wdata_i & PIN_MASK))
        else $error("direction write misplaced");

    a_sample_gap: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && smp_tick |=> !smp_tick [*6])
        else $error("pins sampled too often");

    a_oe_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i |=> pin_oe_o == $past(PIN_MASK & ((~pin_function_select_q & pin_direction_config_q)
                                    | (pin_function_select_q & ALT_OUT_MASK))))
        else $error("driver enable wrong");

    a_gpio_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i |=> (pin_o & $past(out_mode)) == ($past(pin_data_value_q) & $past(out_mode)))
        else $error("output pin not data bit");

    a_alt_resets: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && pin_function_select_q[PIN_RST1] |=> pin_oe_o[PIN_RST1]
                                                   && pin_o[PIN_RST1] == $past(port1_reset_out_n_i))
        else $error("port 1 reset not on pin");

    a_alt_event: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && pin_function_select_q[PIN_EVENT] |=> pin_oe_o[PIN_EVENT]
                                                    && pin_o[PIN_EVENT] == $past(event_out_n_i))
        else $error("event not on pin");

    a_irq_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && !pin_function_select_q[PIN_IRQ0] |=> expander_irq0_in_n_o == IRQ_IDLE)
        else $error("interrupt not idle in gpio mode");

    a_irq_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && pin_function_select_q[PIN_IRQ0] |=> expander_irq0_in_n_o == $past(pin_lvl[PIN_IRQ0]))
        else $error("interrupt not following pin");

    a_input_capture: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i |=> (pin_data_value_q & $past(in_mode)) == ($past(pin_lvl) & $past(in_mode)))
        else $error("input not captured");

    a_read_live: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && cfg_rd_i && cfg_sel_i == GPF_SEL_DATA |=> cfg_rvalid_o
                                                        && cfg_rdata_o == $past(pin_lvl & PIN_MASK))
        else $error("data read not live level");

    c_input_mode: cover property (@(posedge core_clk_i) disable iff (rst_i)
        smp_tick && in_mode[PIN_IRQ0] ##[1:40] pin_data_value_q[PIN_IRQ0]);

    c_output_mode: cover property (@(posedge core_clk_i) disable iff (rst_i)
        out_mode[1] ##1 pin_oe_o[1] && pin_o[1]);

    c_alt_irq: cover property (@(posedge core_clk_i) disable iff (rst_i)
        pin_function_select_q[PIN_IRQ0] ##1 !expander_irq0_in_n_o);

endmodule : gpf_pin_ctrl

// File: hw/gpf_pkg.sv
// ---------------------------------------------------------------
// Shared constants of the pin function control block
// ---------------------------------------------------------------
package gpf_pkg;

    // ---------------------------------------------------------------
    // Pin map
    // ---------------------------------------------------------------
    localparam int unsigned PIN_W        = 10;       // Bit positions follow pin numbers 0..9
    localparam logic [9:0]  PIN_MASK     = 10'h38f;  // Seven implemented pins: 0,1,2,3,7,8,9
    localparam logic [9:0]  ALT_OUT_MASK = 10'h381;  // Pins whose alternate function drives
    localparam int unsigned PIN_RST2     = 0;        // Alternate: downstream port 2 reset
    localparam int unsigned PIN_IRQ0     = 2;        // Alternate: expander interrupt 0 input
    localparam int unsigned PIN_EVENT    = 7;        // Alternate: general purpose event
    localparam int unsigned PIN_RST1     = 8;        // Alternate: downstream port 1 reset
    localparam int unsigned PIN_RST3     = 9;        // Alternate: downstream port 3 reset

    // ---------------------------------------------------------------
    // Reset values and idle levels
    // ---------------------------------------------------------------
    localparam logic [9:0]  FUNC_RST     = 10'h000;  // All pins general purpose
    localparam logic [9:0]  DIR_RST      = 10'h000;  // All pins input
    localparam logic [9:0]  DATA_RST     = 10'h000;  // Output latch cleared
    localparam logic        IRQ_IDLE     = 1'b1;     // Active-low interrupt, idle high

    // ---------------------------------------------------------------
    // Sampling timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_NS       = 20;       // Core clock period
    localparam int unsigned SAMPLE_NS    = 128;      // Least time between input samples
    localparam int unsigned SAMPLE_CYC   = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;

    // ---------------------------------------------------------------
    // Register select on the configuration port
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        GPF_SEL_FUNC,
        GPF_SEL_DIR,
        GPF_SEL_DATA,
        GPF_SEL_NONE
    } gpf_sel_e;

endpackage : gpf_pkg

// File: hw/gpf_sync3.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ---------------------------------------------------------------
module gpf_sync3 #(
    parameter int unsigned W = 10
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // Sample strobe
    input  wire logic         tick_i,
    // Raw pins and filtered level
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;  // Metastable stage, read only by s2
    logic [W-1:0] s2_q;  // Second stage
    logic [W-1:0] s3_q;  // Third stage
    logic [W-1:0] lvl_q; // Accepted level

    // Shift chain advances only on the sample strobe
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce_i && tick_i) begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change is accepted once stages two and three agree
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lvl_q <= '0;
        end else if (ce_i) begin
            lvl_q <= (lvl_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
        end
    end

    assign q_o = lvl_q;

endmodule : gpf_sync3

// File: tb/gpf_board_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Board side of the seven pins
// ---------------------------------------------------------------
module gpf_board_model
    import gpf_pkg::*;
(
    // Clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      rst_i,
    // Device side of the pads
    input  wire logic [gpf_pkg::PIN_W-1:0] dev_pin_i,
    input  wire logic [gpf_pkg::PIN_W-1:0] dev_oe_i,
    // Board drivers set by the bench
    input  wire logic [gpf_pkg::PIN_W-1:0] board_val_i,
    input  wire logic [gpf_pkg::PIN_W-1:0] board_en_i,
    // Resolved pad level and what the board logic sees
    output logic      [gpf_pkg::PIN_W-1:0] pin_lvl_o,
    output logic      [gpf_pkg::PIN_W-1:0] seen_o
);
    logic [PIN_W-1:0] float_q;  // Floating pads, no pull resistor
    logic [PIN_W-1:0] sync1_q;  // First receiver stage
    logic [PIN_W-1:0] sync2_q;  // Second receiver stage

    // Floating pads wander every cycle, so a stale level never passes
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            float_q <= '0;
        end else begin
            float_q <= ~float_q;
        end
    end

    // Board releases a pad while the device drives it
    assign pin_lvl_o = (dev_oe_i & dev_pin_i) | (~dev_oe_i & board_en_i & board_val_i)
                     | (~dev_oe_i & ~board_en_i & float_q);

    // Outputs are asynchronous to the board, so two stages first
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_lvl_o;
            sync2_q <= sync1_q;
        end
    end
    assign seen_o = sync2_q;
endmodule : gpf_board_model

// File: tb/gpio_pin_function_control_test.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Self-checking bench of the pin function control
// ---------------------------------------------------------------
module gpio_pin_function_control_test;
    import gpf_pkg::*;
    logic              clk = 1'b0;          // Core clock
    logic              rst = 1'b1;          // Reset, active high
    logic              ce = 1'b1;           // Clock enable, low freezes the block
    logic              wr = 1'b0;           // Write strobe
    logic              rd = 1'b0;           // Read strobe
    gpf_sel_e          sel = GPF_SEL_NONE;  // Register select
    logic [PIN_W-1:0]  wdata = '0;          // Write data
    logic [PIN_W-1:0]  rdata;               // Read data
    logic              rvalid;              // Read answer
    logic [PIN_W-1:0]  lvl, po, poe, seen;  // Pad level, drive, enable, seen
    logic              p2 = 1'b1, p1 = 1'b1, p3 = 1'b1, ev = 1'b1;  // Alternate sources
    logic              irq;                 // Expander interrupt sink
    logic [PIN_W-1:0]  bval = '0;           // Board drive value
    int                error_cnt = 0;
    int                n_checks = 0;
    int                cyc = 0;             // Cycle count for the hang guard

    always #10 clk = ~clk;

    gpf_pin_ctrl #(.SAMPLE_CYCLES(SAMPLE_CYC)) dut_u (
        .core_clk_i(clk), .rst_i(rst), .ce_i(ce),
        .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_sel_i(sel), .cfg_wdata_i(wdata),
        .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
        .pin_i(lvl), .pin_o(po), .pin_oe_o(poe),
        .port2_reset_out_n_i(p2), .port1_reset_out_n_i(p1), .port3_reset_out_n_i(p3),
        .event_out_n_i(ev), .expander_irq0_in_n_o(irq)
    );

    gpf_board_model board_u (
        .core_clk_i(clk), .rst_i(rst), .dev_pin_i(po), .dev_oe_i(poe),
        .board_val_i(bval), .board_en_i(10'h3ff), .pin_lvl_o(lvl), .seen_o(seen)
    );

    // ---------------------------------------------------------------
    // Compare, report and bus helpers
    // ---------------------------------------------------------------
    task automatic chk_word(input logic [PIN_W-1:0] got, input logic [PIN_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // Write pulse, then wait until the pads follow
    task automatic cfg_write(input gpf_sel_e s, input logic [PIN_W-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        sel <= s;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask : cfg_write

    // Read pulse; answer is valid for exactly one cycle
    task automatic cfg_read(input gpf_sel_e s, input logic [PIN_W-1:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        sel <= s;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_bit(rvalid, 1'b1);
        chk_word(rdata, exp);
        @(posedge clk);
        #1;
        chk_bit(rvalid, 1'b0);
    endtask : cfg_read

    // Longer than the worst synchroniser delay
    task automatic settle();
        repeat (40) @(posedge clk);
    endtask : settle

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk_word(poe, 10'h000);
        chk_word(po, 10'h000);
        chk_bit(irq, 1'b1);
        cfg_read(GPF_SEL_FUNC, 10'h000);
        cfg_read(GPF_SEL_DIR, 10'h000);
        cfg_read(GPF_SEL_NONE, 10'h000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_input();
        @(posedge clk);
        bval <= 10'h375;
        repeat (5) @(posedge clk);
        cfg_read(GPF_SEL_DATA, 10'h000);
        settle();
        cfg_read(GPF_SEL_DATA, 10'h305);
        cfg_write(GPF_SEL_DATA, 10'h000);
        cfg_read(GPF_SEL_DATA, 10'h305);
        @(posedge clk);
        bval <= 10'h301;
        settle();
        chk_bit(irq, 1'b1);
        cfg_read(GPF_SEL_DATA, 10'h301);
        $display("test input done");
    endtask : t_input

    task automatic t_output();
        cfg_write(GPF_SEL_DIR, 10'h3ff);
        cfg_read(GPF_SEL_DIR, 10'h38f);
        cfg_write(GPF_SEL_DATA, 10'h10a);
        chk_word(poe, 10'h38f);
        chk_word(po & PIN_MASK, 10'h10a);
        settle();
        cfg_read(GPF_SEL_DATA, 10'h10a);
        chk_word(seen & PIN_MASK, 10'h10a);
        $display("test output done");
    endtask : t_output

    task automatic t_alternate();
        logic [PIN_W-1:0] exp;
        cfg_write(GPF_SEL_FUNC, 10'h3ff);
        cfg_read(GPF_SEL_FUNC, 10'h38f);
        chk_word(poe, ALT_OUT_MASK);
        // Every combination of the four alternate sources
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            p2 <= k[0];
            ev <= k[1];
            p1 <= k[2];
            p3 <= k[3];
            @(posedge clk);
            #1;
            exp = {k[3], k[2], k[1], 3'h0, 3'h0, k[0]};
            chk_word(po & ALT_OUT_MASK, exp);
        end
        settle();
        chk_bit(irq, 1'b0);
        cfg_read(GPF_SEL_DATA, 10'h381);
        @(posedge clk);
        bval <= 10'h30f;
        settle();
        chk_bit(irq, 1'b1);
        cfg_read(GPF_SEL_DATA, 10'h38f);
        $display("test alternate done");
    endtask : t_alternate

    task automatic t_release();
        cfg_write(GPF_SEL_FUNC, 10'h000);
        cfg_write(GPF_SEL_DIR, 10'h000);
        chk_word(poe, 10'h000);
        $display("test release done");
    endtask : t_release

    // Writes made while the enable is low must not land
    task automatic t_hold();
        @(posedge clk);
        ce <= 1'b0;
        cfg_write(GPF_SEL_DIR, 10'h3ff);
        chk_word(poe, 10'h000);
        @(posedge clk);
        ce <= 1'b1;
        cfg_read(GPF_SEL_DIR, 10'h000);
        $display("test hold done");
    endtask : t_hold

    // Hang guard, well beyond the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            $display("MISMATCH t=%0t run did not finish", $time);
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_input();
        t_output();
        t_alternate();
        t_release();
        t_hold();
        end_of_test();
    end
endmodule : gpio_pin_function_control_test
